// ### can_wake_status_regs_test.sv
// self-checking bench for the CAN and wake status bank
`timescale 1ns/1ns
`default_nettype none
module can_wake_status_regs_test;
    logic                   ref_clk = 1'h0, rst_n = 1'h0, soft_reset = 1'h0;
    logic                   restart_entry = 1'h0, supply_low_raw = 1'h0, failsafe_wake = 1'h0;
    logic                   bus_wake_evt = 1'h0, timer_wake_evt = 1'h0, wake_pin_evt = 1'h0;
    logic                   gpio_wake_evt = 1'h0, gpio_overcurrent_evt = 1'h0;
    logic                   wake_in_enable = 1'h0, hv_measure_enable = 1'h0;
    logic                   cyclic_active = 1'h0, sample_strobe = 1'h0;
    logic [1:0]             can_mode = 2'h0;
    cws_pkg::cws_mode_t     sbc_mode = cws_pkg::CWS_MODE_NORMAL;
    cws_pkg::cws_can_evt_t  can_evt = 3'h0;
    cws_pkg::cws_wake_src_t failsafe_wake_src = cws_pkg::CWS_SRC_BUS;
    cws_pkg::cws_pins_t     pins = 4'h0;
    cws_pkg::cws_gpio_cfg_t gpio_cfg = cws_pkg::CWS_GPIO_OFF;
    cws_pkg::cws_acc_t      acc;
    logic [7:0]             rd_data_q;
    logic                   rd_valid_q, rd_err_q, can_tx_disable_q;
    int                     miscompares = 0, checks = 0;
    logic [6:0]             fa [4] = '{cws_pkg::ADDR_BUS_COMM_STATUS, cws_pkg::ADDR_WAKE_SOURCE_A,
                                       cws_pkg::ADDR_WAKE_SOURCE_B, cws_pkg::ADDR_GPIO_OVERCURRENT};
    cws_pkg::cws_can_evt_t  evt_t [4] = '{3'h4, 3'h2, 3'h1, 3'h7};
    logic [7:0]             code_t [4] = '{8'h02, 8'h04, 8'h06, 8'h06};
    int                     wk_i [4] = '{1, 1, 1, 2};
    logic [7:0]             wk_v [4] = '{8'h20, 8'h10, 8'h01, 8'h10};
    cws_pkg::cws_gpio_cfg_t oc_cfg [3] = '{cws_pkg::CWS_GPIO_OFF, cws_pkg::CWS_GPIO_LOW_SIDE,
                                           cws_pkg::CWS_GPIO_HIGH_SIDE};
    logic [7:0]             oc_v [3] = '{8'h00, 8'h40, 8'h40};

    cws_status_bank dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .sbc_mode(sbc_mode), .soft_reset(soft_reset),
        .restart_entry(restart_entry), .can_evt(can_evt), .supply_low_raw(supply_low_raw),
        .can_mode(can_mode), .bus_wake_evt(bus_wake_evt), .timer_wake_evt(timer_wake_evt),
        .wake_pin_evt(wake_pin_evt), .gpio_wake_evt(gpio_wake_evt),
        .failsafe_wake(failsafe_wake), .failsafe_wake_src(failsafe_wake_src), .pins(pins),
        .gpio_cfg(gpio_cfg), .wake_in_enable(wake_in_enable),
        .hv_measure_enable(hv_measure_enable), .cyclic_active(cyclic_active),
        .sample_strobe(sample_strobe), .gpio_overcurrent_evt(gpio_overcurrent_evt),
        .acc(acc), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q), .rd_err_q(rd_err_q),
        .can_tx_disable_q(can_tx_disable_q));

    cws_host_model host (
        .ref_clk(ref_clk), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
        .rd_err_q(rd_err_q), .acc(acc));

    initial forever #5 ref_clk = ~ref_clk;

    task automatic test_done;
        if (miscompares == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] a, input logic [7:0] e);
        checks++;
        if (a !== e)
        begin
            miscompares++;
            $display("Error t=%0t got %h exp %h", $time, a, e);
        end
    endtask

    task automatic rd(input logic [6:0] a, input logic c, input logic [7:0] e, input logic ee);
        logic [7:0] d;
        logic       r;
        host.access(a, c, d, r);
        chk(d, e);
        chk({7'h00, r}, {7'h00, ee});
    endtask

    initial
    begin
        repeat (5000) @(posedge ref_clk);
        miscompares++;
        test_done();
    end

    initial
    begin
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'h1;
        foreach (fa[i]) rd(fa[i], 1'h0, 8'h00, 1'h0);
        rd(cws_pkg::ADDR_INPUT_LEVEL, 1'h0, 8'h00, 1'h0);
        rd(7'h45, 1'h1, 8'h00, 1'h1);
        rd(7'h7F, 1'h0, 8'h00, 1'h1);
        // each fault alone gives its own code, all three at once leave the worst code
        for (int i = 0; i < 4; i++)
        begin
            @(posedge ref_clk) can_evt <= evt_t[i];
            @(posedge ref_clk) can_evt <= 3'h0;
            rd(fa[0], 1'h1, code_t[i], 1'h0);
        end
        rd(fa[0], 1'h0, 8'h00, 1'h0);
        // direct wake events first, then the same sources out of fail-safe
        for (int i = 0; i < 8; i++)
        begin
            @(posedge ref_clk);
            {bus_wake_evt, timer_wake_evt, wake_pin_evt, gpio_wake_evt} <= 4'h8 >> i;
            failsafe_wake <= (i >= 4);
            failsafe_wake_src <= cws_pkg::cws_wake_src_t'(2'(i));
            @(posedge ref_clk);
            {bus_wake_evt, timer_wake_evt, wake_pin_evt, gpio_wake_evt, failsafe_wake} <= 5'h00;
            rd(fa[wk_i[i % 4]], 1'h0, wk_v[i % 4], 1'h0);
            rd(fa[wk_i[i % 4]], 1'h1, wk_v[i % 4], 1'h0);
            rd(fa[wk_i[i % 4]], 1'h0, 8'h00, 1'h0);
        end
        @(posedge ref_clk);
        can_mode <= 2'h1;
        supply_low_raw <= 1'h1;
        rd(fa[0], 1'h0, 8'h00, 1'h0);
        @(posedge ref_clk) can_mode <= 2'h2;
        rd(fa[0], 1'h0, 8'h01, 1'h0);
        chk({7'h00, can_tx_disable_q}, 8'h01);
        @(posedge ref_clk) supply_low_raw <= 1'h0;
        rd(fa[0], 1'h1, 8'h01, 1'h0);
        rd(fa[0], 1'h0, 8'h00, 1'h0);
        for (int i = 0; i < 3; i++)
        begin
            @(posedge ref_clk);
            gpio_cfg <= oc_cfg[i];
            gpio_overcurrent_evt <= 1'h1;
            @(posedge ref_clk) gpio_overcurrent_evt <= 1'h0;
            rd(fa[3], 1'h1, oc_v[i], 1'h0);
        end
        // restart keeps all but the gpio wake flag, soft reset clears all
        @(posedge ref_clk) {can_evt, bus_wake_evt, gpio_wake_evt, gpio_overcurrent_evt} <= 6'h27;
        @(posedge ref_clk) {can_evt, bus_wake_evt, gpio_wake_evt, gpio_overcurrent_evt} <= 6'h00;
        restart_entry <= 1'h1;
        @(posedge ref_clk) restart_entry <= 1'h0;
        rd(fa[0], 1'h0, 8'h02, 1'h0);
        rd(fa[1], 1'h0, 8'h20, 1'h0);
        rd(fa[2], 1'h0, 8'h00, 1'h0);
        rd(fa[3], 1'h0, 8'h40, 1'h0);
        @(posedge ref_clk) soft_reset <= 1'h1;
        @(posedge ref_clk) soft_reset <= 1'h0;
        foreach (fa[i]) rd(fa[i], 1'h0, 8'h00, 1'h0);
        // pin levels, then freezing by function, mode and sampling
        @(posedge ref_clk);
        pins <= 4'hF;
        gpio_cfg <= cws_pkg::CWS_GPIO_WAKE_IN;
        wake_in_enable <= 1'h1;
        rd(cws_pkg::ADDR_INPUT_LEVEL, 1'h0, 8'hD1, 1'h0);
        @(posedge ref_clk);
        pins <= 4'hC;
        gpio_cfg <= cws_pkg::CWS_GPIO_FAIL_OUT;
        wake_in_enable <= 1'h0;
        rd(cws_pkg::ADDR_INPUT_LEVEL, 1'h1, 8'hD1, 1'h0);
        @(posedge ref_clk);
        sbc_mode <= cws_pkg::CWS_MODE_SLEEP;
        pins <= 4'h0;
        gpio_cfg <= cws_pkg::CWS_GPIO_LOW_SIDE;
        wake_in_enable <= 1'h1;
        rd(cws_pkg::ADDR_INPUT_LEVEL, 1'h0, 8'hD1, 1'h0);
        @(posedge ref_clk) cyclic_active <= 1'h1;
        rd(cws_pkg::ADDR_INPUT_LEVEL, 1'h0, 8'hD1, 1'h0);
        @(posedge ref_clk) sample_strobe <= 1'h1;
        @(posedge ref_clk) sample_strobe <= 1'h0;
        rd(cws_pkg::ADDR_INPUT_LEVEL, 1'h0, 8'h00, 1'h0);
        @(posedge ref_clk);
        sbc_mode <= cws_pkg::CWS_MODE_STOP;
        cyclic_active <= 1'h0;
        pins <= 4'hF;
        rd(cws_pkg::ADDR_INPUT_LEVEL, 1'h0, 8'hD1, 1'h0);
        @(posedge ref_clk) hv_measure_enable <= 1'h1;
        rd(cws_pkg::ADDR_INPUT_LEVEL, 1'h0, 8'hC0, 1'h0);
        test_done();
    end
endmodule
`default_nettype wire

// ### cws_flag.sv
// one sticky status flag with soft reset, restart and host clear
`timescale 1ns/1ns
`default_nettype none
module cws_flag #(
    parameter bit KEEP_ON_RESTART = 1'b1
) (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_n,
    // controls
    input  wire logic set,
    input  wire logic clr,
    input  wire logic soft_rst,
    input  wire logic restart,
    // state
    output var  logic flag_q
);

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            flag_q <= 1'b0;
        else if (soft_rst)
            flag_q <= 1'b0;
        else if (set)
            flag_q <= 1'b1;
        else if (clr || (restart && !KEEP_ON_RESTART))
            flag_q <= 1'b0;
    end

endmodule
`default_nettype wire

// ### cws_host_model.sv
// host side model: issues register accesses and collects the answers
`timescale 1ns/1ns
`default_nettype none
module cws_host_model (
    // clock
    input wire logic                       ref_clk,
    // answers from the bank
    input wire logic [cws_pkg::DATA_W-1:0] rd_data_q,
    input wire logic                       rd_valid_q,
    input wire logic                       rd_err_q,
    // request
    output var cws_pkg::cws_acc_t          acc
);
    initial acc = '{1'h0, 1'h0, 7'h00};

    // idle bus shows the inverted address so a stale value never decodes
    task automatic access(input logic [6:0] a, input logic c, output logic [7:0] d,
                          output logic e);
        int n;
        n = 0;
        @(posedge ref_clk);
        acc <= '{1'h1, c, a};
        @(posedge ref_clk);
        acc <= '{1'h0, 1'h0, ~a};
        do
        begin
            @(posedge ref_clk);
            n++;
        end while (rd_valid_q !== 1'h1 && n < 4);
        d = (rd_valid_q === 1'h1) ? rd_data_q : 8'hXX;
        e = rd_err_q;
    endtask
endmodule
`default_nettype wire

// ### cws_pkg.sv
// shared constants, encodings and carrier types of the CAN and wake status bank
package cws_pkg;

    localparam int unsigned ADDR_W = 7;
    localparam int unsigned DATA_W = 8;

    // register addresses, seven-bit
    localparam logic [ADDR_W-1:0] ADDR_BUS_COMM_STATUS   = 7'h44;
    localparam logic [ADDR_W-1:0] ADDR_WAKE_SOURCE_A     = 7'h46;
    localparam logic [ADDR_W-1:0] ADDR_WAKE_SOURCE_B     = 7'h47;
    localparam logic [ADDR_W-1:0] ADDR_INPUT_LEVEL       = 7'h48;
    localparam logic [ADDR_W-1:0] ADDR_GPIO_OVERCURRENT  = 7'h54;

    localparam logic [DATA_W-1:0] RESET_VALUE = 8'h00;
    localparam logic [DATA_W-1:0] READ_ZERO   = 8'h00;

    // bit positions inside the registers
    localparam int unsigned BIT_SUPPLY_LOW     = 0;
    localparam int unsigned BIT_CAN_FAIL_LO    = 1;
    localparam int unsigned BIT_CAN_FAIL_HI    = 2;
    localparam int unsigned BIT_BUS_WAKE       = 5;
    localparam int unsigned BIT_TIMER_WAKE     = 4;
    localparam int unsigned BIT_WAKE_PIN       = 0;
    localparam int unsigned BIT_GPIO_WAKE      = 4;
    localparam int unsigned BIT_DEV_MODE_LVL   = 7;
    localparam int unsigned BIT_PULLUP_CFG     = 6;
    localparam int unsigned BIT_GPIO_PIN_LEVEL       = 4;
    localparam int unsigned BIT_WAKE_LVL       = 0;
    localparam int unsigned BIT_GPIO_OVERCURRENT_FLAG        = 6;
    localparam int unsigned BIT_CAN_MODE_UPPER = 1;

    // single sticky flags, index into the flag vector
    localparam int unsigned FLG_SUPPLY_LOW = 0;
    localparam int unsigned FLG_BUS_WAKE   = 1;
    localparam int unsigned FLG_TIMER_WAKE = 2;
    localparam int unsigned FLG_WAKE_PIN   = 3;
    localparam int unsigned FLG_GPIO_WAKE  = 4;
    localparam int unsigned FLG_GPIO_OVERCURRENT_FLAG    = 5;
    localparam int unsigned NUM_FLAGS      = 6;

    // flags that survive a restart
    localparam logic [NUM_FLAGS-1:0] RESTART_KEEP = 6'h2F;

    // can failure codes
    localparam logic [1:0] CAN_FAIL_NONE    = 2'h0;
    localparam logic [1:0] CAN_FAIL_TSD     = 2'h1;
    localparam logic [1:0] CAN_FAIL_TXD_DOM = 2'h2;
    localparam logic [1:0] CAN_FAIL_BUS_DOM = 2'h3;

    typedef enum logic [2:0] {
        CWS_MODE_NORMAL    = 3'h0,
        CWS_MODE_STOP      = 3'h1,
        CWS_MODE_INIT      = 3'h2,
        CWS_MODE_RESTART   = 3'h3,
        CWS_MODE_SLEEP     = 3'h4,
        CWS_MODE_FAIL_SAFE = 3'h5
    } cws_mode_t;

    typedef enum logic [2:0] {
        CWS_GPIO_OFF        = 3'h0,
        CWS_GPIO_FAIL_OUT   = 3'h1,
        CWS_GPIO_WAKE_IN    = 3'h2,
        CWS_GPIO_LOW_SIDE   = 3'h3,
        CWS_GPIO_HIGH_SIDE  = 3'h4
    } cws_gpio_cfg_t;

    typedef enum logic [1:0] {
        CWS_SRC_BUS   = 2'h0,
        CWS_SRC_TIMER = 2'h1,
        CWS_SRC_PIN   = 2'h2,
        CWS_SRC_GPIO  = 2'h3
    } cws_wake_src_t;

    typedef struct packed {
        logic              valid;
        logic              clear;
        logic [ADDR_W-1:0] addr;
    } cws_acc_t;

    typedef struct packed {
        logic tsd;
        logic txd_dom;
        logic bus_dom;
    } cws_can_evt_t;

    typedef struct packed {
        logic test_pin;
        logic pullup_sense;
        logic gpio_pin;
        logic wake_pin;
    } cws_pins_t;

endpackage

// ### cws_status_bank.sv
// CAN fault, wake source, pin level and gpio overcurrent status registers
//
// Contract
// - two-bit CAN fault code, four values
// - supply low sets bit 0, disables transmitter
// - supply comparator active only when mode bit high
// - bus status at 0x44, restart keeps bits
// - reserved bits always read zero
// - one sticky wake flag per wake source
// - fail-safe wake also sets source flag
// - bit 7 shows test pin mode
// - bit 6 shows interrupt pin pull-up sense
// - gpio level bit 4, wake level bit 0
// - levels refresh in active modes, only per sample under cyclic sensing
// - disabled function freezes its level bit
// - hv measurement forces gpio and wake level bits to zero
// - switch overcurrent sets gpio flag bit 6
// - fail output state not shown in level
// - wake registers 0x46, 0x47, level 0x48
`timescale 1ns/1ns
`default_nettype none
module cws_status_bank (
    // clock and reset
    input  wire logic                           ref_clk,
    input  wire logic                           rst_n,
    // device state
    input  wire cws_pkg::cws_mode_t             sbc_mode,
    input  wire logic                           soft_reset,
    input  wire logic                           restart_entry,
    // can transceiver
    input  wire cws_pkg::cws_can_evt_t          can_evt,
    input  wire logic                           supply_low_raw,
    input  wire logic [1:0]                     can_mode,
    // wake events
    input  wire logic                           bus_wake_evt,
    input  wire logic                           timer_wake_evt,
    input  wire logic                           wake_pin_evt,
    input  wire logic                           gpio_wake_evt,
    input  wire logic                           failsafe_wake,
    input  wire cws_pkg::cws_wake_src_t         failsafe_wake_src,
    // pins and their configuration
    input  wire cws_pkg::cws_pins_t             pins,
    input  wire cws_pkg::cws_gpio_cfg_t         gpio_cfg,
    input  wire logic                           wake_in_enable,
    input  wire logic                           hv_measure_enable,
    input  wire logic                           cyclic_active,
    input  wire logic                           sample_strobe,
    input  wire logic                           gpio_overcurrent_evt,
    // register access
    input  wire cws_pkg::cws_acc_t              acc,
    output var  logic [cws_pkg::DATA_W-1:0]     rd_data_q,
    output var  logic                           rd_valid_q,
    output var  logic                           rd_err_q,
    // transmitter control
    output var  logic                           can_tx_disable_q
);

    logic [cws_pkg::NUM_FLAGS-1:0] flag_set;
    logic [cws_pkg::NUM_FLAGS-1:0] flag_clr;
    logic [cws_pkg::NUM_FLAGS-1:0] flag_q;

    logic       sel_bus;
    logic       sel_wake_a;
    logic       sel_wake_b;
    logic       sel_level;
    logic       sel_oc;
    logic       clr_bus;
    logic       clr_wake_a;
    logic       clr_wake_b;
    logic       clr_oc;
    logic       supply_low_det;
    logic [1:0] can_fail_new;
    logic [1:0] can_fail_q;
    logic       mode_refresh;
    logic       level_refresh;
    logic       gpio_level_live;
    logic       fs_bus;
    logic       fs_timer;
    logic       fs_pin;
    logic       fs_gpio;

    logic       lvl_dev_q;
    logic       lvl_pullup_q;
    logic       lvl_gpio_q;
    logic       lvl_wake_q;

    logic [cws_pkg::DATA_W-1:0] bus_word;
    logic [cws_pkg::DATA_W-1:0] wake_a_word;
    logic [cws_pkg::DATA_W-1:0] wake_b_word;
    logic [cws_pkg::DATA_W-1:0] level_word;
    logic [cws_pkg::DATA_W-1:0] oc_word;
    logic [cws_pkg::DATA_W-1:0] rd_mux;
    logic                       rd_hit;

    // address decode
    assign sel_bus    = (acc.addr == cws_pkg::ADDR_BUS_COMM_STATUS);
    assign sel_wake_a = (acc.addr == cws_pkg::ADDR_WAKE_SOURCE_A);
    assign sel_wake_b = (acc.addr == cws_pkg::ADDR_WAKE_SOURCE_B);
    assign sel_level  = (acc.addr == cws_pkg::ADDR_INPUT_LEVEL);
    assign sel_oc     = (acc.addr == cws_pkg::ADDR_GPIO_OVERCURRENT);
    assign rd_hit     = sel_bus | sel_wake_a | sel_wake_b | sel_level | sel_oc;

    // clearing accesses; the level register has nothing to clear
    assign clr_bus    = acc.valid & acc.clear & sel_bus;
    assign clr_wake_a = acc.valid & acc.clear & sel_wake_a;
    assign clr_wake_b = acc.valid & acc.clear & sel_wake_b;
    assign clr_oc     = acc.valid & acc.clear & sel_oc;

    // supply comparator gated by the upper can mode bit
    assign supply_low_det = supply_low_raw & can_mode[cws_pkg::BIT_CAN_MODE_UPPER];

    // fail-safe wake decoded to its source
    assign fs_bus   = failsafe_wake & (failsafe_wake_src == cws_pkg::CWS_SRC_BUS);
    assign fs_timer = failsafe_wake & (failsafe_wake_src == cws_pkg::CWS_SRC_TIMER);
    assign fs_pin   = failsafe_wake & (failsafe_wake_src == cws_pkg::CWS_SRC_PIN);
    assign fs_gpio  = failsafe_wake & (failsafe_wake_src == cws_pkg::CWS_SRC_GPIO);

    always_comb
    begin
        flag_set = '0;
        flag_set[cws_pkg::FLG_SUPPLY_LOW] = supply_low_det;
        flag_set[cws_pkg::FLG_BUS_WAKE]   = bus_wake_evt | fs_bus;
        flag_set[cws_pkg::FLG_TIMER_WAKE] = timer_wake_evt | fs_timer;
        flag_set[cws_pkg::FLG_WAKE_PIN]   = wake_pin_evt | fs_pin;
        flag_set[cws_pkg::FLG_GPIO_WAKE]  = gpio_wake_evt | fs_gpio;
        // overcurrent only counts while the pin is a switch
        flag_set[cws_pkg::FLG_GPIO_OVERCURRENT_FLAG]    = gpio_overcurrent_evt &
            ((gpio_cfg == cws_pkg::CWS_GPIO_LOW_SIDE) ||
             (gpio_cfg == cws_pkg::CWS_GPIO_HIGH_SIDE));
    end

    always_comb
    begin
        flag_clr = '0;
        flag_clr[cws_pkg::FLG_SUPPLY_LOW] = clr_bus;
        flag_clr[cws_pkg::FLG_BUS_WAKE]   = clr_wake_a;
        flag_clr[cws_pkg::FLG_TIMER_WAKE] = clr_wake_a;
        flag_clr[cws_pkg::FLG_WAKE_PIN]   = clr_wake_a;
        flag_clr[cws_pkg::FLG_GPIO_WAKE]  = clr_wake_b;
        flag_clr[cws_pkg::FLG_GPIO_OVERCURRENT_FLAG]    = clr_oc;
    end

    genvar gi;
    generate
        for (gi = 0; gi < cws_pkg::NUM_FLAGS; gi++)
        begin : g_flag
            cws_flag #(
                .KEEP_ON_RESTART (cws_pkg::RESTART_KEEP[gi])
            ) u_flag (
                .ref_clk  (ref_clk),
                .rst_n    (rst_n),
                .set      (flag_set[gi]),
                .clr      (flag_clr[gi]),
                .soft_rst (soft_reset),
                .restart  (restart_entry),
                .flag_q   (flag_q[gi])
            );
        end
    endgenerate

    // bus dominant outranks txd dominant outranks thermal shutdown
    always_comb
    begin
        if (can_evt.bus_dom)
            can_fail_new = cws_pkg::CAN_FAIL_BUS_DOM;
        else if (can_evt.txd_dom)
            can_fail_new = cws_pkg::CAN_FAIL_TXD_DOM;
        else if (can_evt.tsd)
            can_fail_new = cws_pkg::CAN_FAIL_TSD;
        else
            can_fail_new = cws_pkg::CAN_FAIL_NONE;
    end

    // fault code survives a restart; a new fault beats a clear
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            can_fail_q <= cws_pkg::CAN_FAIL_NONE;
        else if (soft_reset)
            can_fail_q <= cws_pkg::CAN_FAIL_NONE;
        else if (can_fail_new != cws_pkg::CAN_FAIL_NONE)
            can_fail_q <= can_fail_new;
        else if (clr_bus)
            can_fail_q <= cws_pkg::CAN_FAIL_NONE;
    end

    // transmitter off while the gated comparator reports low supply
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            can_tx_disable_q <= 1'b0;
        else
            can_tx_disable_q <= supply_low_det;
    end

    // modes in which the live levels are tracked
    always_comb
    begin
        unique case (sbc_mode)
            cws_pkg::CWS_MODE_NORMAL,
            cws_pkg::CWS_MODE_STOP,
            cws_pkg::CWS_MODE_INIT,
            cws_pkg::CWS_MODE_RESTART:   mode_refresh = 1'b1;
            cws_pkg::CWS_MODE_SLEEP,
            cws_pkg::CWS_MODE_FAIL_SAFE: mode_refresh = 1'b0;
            default:                     mode_refresh = 1'b0;
        endcase
    end

    // cyclic sensing loads only the sampled value, in any mode
    assign level_refresh = cyclic_active ? sample_strobe : mode_refresh;

    // fail output and an unused pin leave the gpio level untouched
    assign gpio_level_live = (gpio_cfg == cws_pkg::CWS_GPIO_WAKE_IN) ||
                             (gpio_cfg == cws_pkg::CWS_GPIO_LOW_SIDE) ||
                             (gpio_cfg == cws_pkg::CWS_GPIO_HIGH_SIDE);

    // mode and configuration levels are not affected by measurement
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            lvl_dev_q    <= 1'b0;
            lvl_pullup_q <= 1'b0;
        end
        else if (level_refresh)
        begin
            lvl_dev_q    <= pins.test_pin;
            lvl_pullup_q <= pins.pullup_sense;
        end
    end

    // measurement shares the pins, so their levels mean nothing then
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            lvl_gpio_q <= 1'b0;
        else if (hv_measure_enable)
            lvl_gpio_q <= 1'b0;
        else if (level_refresh && gpio_level_live)
            lvl_gpio_q <= pins.gpio_pin;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            lvl_wake_q <= 1'b0;
        else if (hv_measure_enable)
            lvl_wake_q <= 1'b0;
        else if (level_refresh && wake_in_enable)
            lvl_wake_q <= pins.wake_pin;
    end

    // read words; every position not named here stays zero
    always_comb
    begin
        bus_word    = cws_pkg::READ_ZERO;
        wake_a_word = cws_pkg::READ_ZERO;
        wake_b_word = cws_pkg::READ_ZERO;
        level_word  = cws_pkg::READ_ZERO;
        oc_word     = cws_pkg::READ_ZERO;
        bus_word[cws_pkg::BIT_SUPPLY_LOW] = flag_q[cws_pkg::FLG_SUPPLY_LOW];
        bus_word[cws_pkg::BIT_CAN_FAIL_HI:cws_pkg::BIT_CAN_FAIL_LO] = can_fail_q;
        wake_a_word[cws_pkg::BIT_BUS_WAKE]   = flag_q[cws_pkg::FLG_BUS_WAKE];
        wake_a_word[cws_pkg::BIT_TIMER_WAKE] = flag_q[cws_pkg::FLG_TIMER_WAKE];
        wake_a_word[cws_pkg::BIT_WAKE_PIN]   = flag_q[cws_pkg::FLG_WAKE_PIN];
        wake_b_word[cws_pkg::BIT_GPIO_WAKE]  = flag_q[cws_pkg::FLG_GPIO_WAKE];
        level_word[cws_pkg::BIT_DEV_MODE_LVL] = lvl_dev_q;
        level_word[cws_pkg::BIT_PULLUP_CFG]   = lvl_pullup_q;
        level_word[cws_pkg::BIT_GPIO_PIN_LEVEL]     = lvl_gpio_q;
        level_word[cws_pkg::BIT_WAKE_LVL]     = lvl_wake_q;
        oc_word[cws_pkg::BIT_GPIO_OVERCURRENT_FLAG] = flag_q[cws_pkg::FLG_GPIO_OVERCURRENT_FLAG];
    end

    always_comb
    begin
        rd_mux = cws_pkg::READ_ZERO;
        if (sel_bus)
            rd_mux = bus_word;
        else if (sel_wake_a)
            rd_mux = wake_a_word;
        else if (sel_wake_b)
            rd_mux = wake_b_word;
        else if (sel_level)
            rd_mux = level_word;
        else if (sel_oc)
            rd_mux = oc_word;
    end

    // the answer carries the value before any clear of the same access
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            rd_data_q  <= cws_pkg::RESET_VALUE;
            rd_valid_q <= 1'b0;
            rd_err_q   <= 1'b0;
        end
        else
        begin
            rd_valid_q <= acc.valid;
            rd_err_q   <= acc.valid & ~rd_hit;
            if (acc.valid)
                rd_data_q <= rd_mux;
        end
    end

endmodule
`default_nettype wire

// ### cws_status_bank_monitor.sv
// concurrent checks on the status bank ports, bound into every instance
`timescale 1ns/1ns
`default_nettype none
module cws_status_bank_monitor (
    // clock and reset
    input wire logic                       ref_clk,
    input wire logic                       rst_n,
    // stimulus side
    input wire logic                       soft_reset,
    input wire cws_pkg::cws_can_evt_t      can_evt,
    input wire logic                       supply_low_raw,
    input wire logic [1:0]                 can_mode,
    input wire logic                       bus_wake_evt,
    input wire cws_pkg::cws_gpio_cfg_t     gpio_cfg,
    input wire logic                       hv_measure_enable,
    input wire logic                       gpio_overcurrent_evt,
    input wire cws_pkg::cws_acc_t          acc,
    // answers
    input wire logic [cws_pkg::DATA_W-1:0] rd_data_q,
    input wire logic                       rd_valid_q,
    input wire logic                       rd_err_q,
    input wire logic                       can_tx_disable_q
);
    default clocking mon_cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    // bits that never read as one; all ones marks an unmapped address
    function automatic logic [7:0] rsv_mask(input logic [6:0] a);
        case (a)
            cws_pkg::ADDR_BUS_COMM_STATUS:  return 8'hF8;
            cws_pkg::ADDR_WAKE_SOURCE_A:    return 8'hCE;
            cws_pkg::ADDR_WAKE_SOURCE_B:    return 8'hEF;
            cws_pkg::ADDR_INPUT_LEVEL:      return 8'h2E;
            cws_pkg::ADDR_GPIO_OVERCURRENT: return 8'hBF;
            default:                        return 8'hFF;
        endcase
    endfunction

    a_valid_answer: assert property (acc.valid |=> rd_valid_q)
        else $error("access not answered one cycle later");
    a_no_spurious: assert property (!acc.valid |=> !rd_valid_q && !rd_err_q)
        else $error("answer without an access");
    a_err_unmapped: assert property (
        acc.valid && rsv_mask(acc.addr) == 8'hFF |=> rd_err_q && rd_data_q == 8'h00)
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (
        acc.valid && rsv_mask(acc.addr) != 8'hFF |=> !rd_err_q)
        else $error("mapped access refused");
    a_reserved_zero: assert property (
        rd_valid_q |-> (rd_data_q & rsv_mask($past(acc.addr))) == 8'h00)
        else $error("reserved bit read as one");
    a_txdis_set: assert property (can_mode[1] && supply_low_raw |=> can_tx_disable_q)
        else $error("transmitter left on under supply low");
    a_txdis_off: assert property (!can_mode[1] |=> !can_tx_disable_q)
        else $error("comparator active with mode bit low");
    a_hv_zero: assert property (
        $past(hv_measure_enable) && acc.valid && acc.addr == cws_pkg::ADDR_INPUT_LEVEL |=>
        rd_data_q[4] == 1'h0 && rd_data_q[0] == 1'h0)
        else $error("level bits not zero in measurement");
    a_code_busdom: assert property (
        can_evt.bus_dom && !soft_reset ##1 !soft_reset && !acc.valid && can_evt == 3'h0 ##1
        acc.valid && acc.addr == cws_pkg::ADDR_BUS_COMM_STATUS |=> rd_data_q[2:1] == 2'h3)
        else $error("bus dominant code missing");
    a_wake_bus: assert property (
        bus_wake_evt && !soft_reset ##1 !soft_reset && !acc.valid ##1
        acc.valid && acc.addr == cws_pkg::ADDR_WAKE_SOURCE_A |=> rd_data_q[5])
        else $error("bus wake flag missing");
    a_oc_switch: assert property (
        gpio_overcurrent_evt && !soft_reset &&
        gpio_cfg inside {cws_pkg::CWS_GPIO_LOW_SIDE, cws_pkg::CWS_GPIO_HIGH_SIDE} ##1
        !soft_reset && !acc.valid ##1
        acc.valid && acc.addr == cws_pkg::ADDR_GPIO_OVERCURRENT |=> rd_data_q[6])
        else $error("overcurrent flag missing");
    a_sticky_hold: assert property (
        acc.valid && !acc.clear && !soft_reset && acc.addr == cws_pkg::ADDR_WAKE_SOURCE_A ##1
        (!acc.valid && !soft_reset)[*2] ##1 acc.valid && acc.addr == cws_pkg::ADDR_WAKE_SOURCE_A
        |=> ($past(rd_data_q) & ~rd_data_q) == 8'h00)
        else $error("flag dropped without a clear");
endmodule

bind cws_status_bank cws_status_bank_monitor u_monitor (
    .ref_clk(ref_clk), .rst_n(rst_n), .soft_reset(soft_reset), .can_evt(can_evt),
    .supply_low_raw(supply_low_raw), .can_mode(can_mode), .bus_wake_evt(bus_wake_evt),
    .gpio_cfg(gpio_cfg), .hv_measure_enable(hv_measure_enable),
    .gpio_overcurrent_evt(gpio_overcurrent_evt), .acc(acc), .rd_data_q(rd_data_q),
    .rd_valid_q(rd_valid_q), .rd_err_q(rd_err_q), .can_tx_disable_q(can_tx_disable_q));
`default_nettype wire
